// ===== sfcrfe_front_end.sv
// Serial flash command decoder and array read path
//
// Behaviour
// - Read opcodes 1B, 0B, 03 accepted, each with own dummy count.
// - Opcode 1B: two dummy bytes follow address, then data out.
// - Opcode 0B: one dummy byte follows address, then data out.
// - Opcode 03: no dummy bytes; data follows address at once.
// - Address counter advances per byte; data streams without new address.
// - Single read shifts data on output line, MSB first.
// - Address counter wraps from last array byte to zero without delay.
// - Chip select release ends single read, output line floats.
// - Dual read 3B: three address bytes, one dummy, two lines out.
// - Dual read: high bit on output, low on aux line; byte/4 clocks.
// - Chip select release ends dual read, both lines float.
// - Program opcodes 02, A2: three address bytes, data bytes follow.
// - Erase opcodes 20, 52, D8 take address; chip erases take none.
// - Protection readback takes address, no dummy; no data is shifted out.
// - Lock and freeze take address then one data byte.
// - Lock readback takes address, no dummy; no data is shifted out.
// - OTP program takes address and data bytes, no dummy.
// - OTP read takes address and two dummy bytes; no data is shifted out.
// - Status commands take no address; writes take one data byte.
// - Identification read takes no address or dummy; no data is shifted out.
// - Power-down entry and wake opcodes take nothing further.
// - Unknown opcode starts nothing; input ignored until reselect.
// - MSB first; sample on rising clock, drive on falling clock.
// - Top four address bits are dropped.
// - Select released before opcode and address complete: nothing done.
`timescale 1ns/1ps
`include "sfcrfe_cfg.svh"
module sfcrfe_front_end (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic spiClk,
  input wire logic chipSelN,
  input wire logic dataIn,
  output logic dataOut,
  output logic dataOutEn,
  input wire logic auxDataLineInOut_i,
  output logic auxDataLineInOut_o,
  output logic auxDataLineInOut_oe,
  output logic [19:0] arrayAddr,
  output logic arrayReq,
  input wire logic arrayAck,
  input wire logic [7:0] arrayData,
  output logic [7:0] cmdOpcode,
  output logic [23:0] cmdAddr,
  output logic cmdStart,
  output logic cmdEnd,
  output logic [7:0] cmdData,
  output logic cmdDataValid,
  output logic cmdBad
);
  logic [2:0] sckSync_q;
  logic [1:0] csSync_q;
  logic [1:0] siSync_q;
  logic [1:0] sioSync_q;
  logic sckRise;
  logic sckFall;
  logic selected;
  logic selStart;
  logic selEnd;
  logic csPrev_q;
  sfcrfe_pkg::sfcrfe_state_t state_q;
  sfcrfe_pkg::sfcrfe_kind_t kind_q;
  sfcrfe_pkg::sfcrfe_kind_t kindDec;
  logic addrDec;
  logic [1:0] dummyDec;
  logic [1:0] dummyNeed_q;
  logic [2:0] bitCnt_q;
  logic [1:0] byteCnt_q;
  logic [7:0] shIn_q;
  logic [7:0] inByte;
  logic byteDone;
  logic [23:0] addr_q;
  logic [19:0] fetchAddr_q;
  logic fetchBusy_q;
  logic [7:0] shOut_q;
  logic [2:0] outBits_q;
  logic outLoaded_q;
  logic dual_q;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoPop;
  logic [7:0] fifoOutData;
  logic readPhase;
  logic fifoFlush;

  // Two-stage sync of every pin; edge finding uses stages two and three
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sckSync_q <= 3'h0;
      csSync_q <= 2'h3;
      siSync_q <= 2'h0;
      sioSync_q <= 2'h0;
    end
    else
    begin
      sckSync_q <= {sckSync_q[1:0], spiClk};
      csSync_q <= {csSync_q[0], chipSelN};
      siSync_q <= {siSync_q[0], dataIn};
      sioSync_q <= {sioSync_q[0], auxDataLineInOut_i};
    end
  end

  assign sckRise = sckSync_q[1] && !sckSync_q[2];
  assign sckFall = !sckSync_q[1] && sckSync_q[2];
  assign selected = !csSync_q[1];

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      csPrev_q <= 1'b1;
    end
    else
    begin
      csPrev_q <= csSync_q[1];
    end
  end

  assign selStart = csPrev_q && !csSync_q[1];
  assign selEnd = !csPrev_q && csSync_q[1];

  assign inByte = {shIn_q[6:0], siSync_q[1]};
  assign byteDone = sckRise && bitCnt_q == 3'h7;

  always_comb
  begin
    kindDec = sfcrfe_pkg::SFCRFE_K_BAD;
    addrDec = 1'b0;
    dummyDec = 2'h0;
    unique case (inByte)
      `SFCRFE_OP_READ_FAST:
      begin
        kindDec = sfcrfe_pkg::SFCRFE_K_READ;
        addrDec = 1'b1;
        dummyDec = 2'h2;
      end
      `SFCRFE_OP_READ_MID:
      begin
        kindDec = sfcrfe_pkg::SFCRFE_K_READ;
        addrDec = 1'b1;
        dummyDec = 2'h1;
      end
      `SFCRFE_OP_READ_SLOW:
      begin
        kindDec = sfcrfe_pkg::SFCRFE_K_READ;
        addrDec = 1'b1;
      end
      `SFCRFE_OP_READ_DUAL:
      begin
        kindDec = sfcrfe_pkg::SFCRFE_K_READ2;
        addrDec = 1'b1;
        dummyDec = 2'h1;
      end
      `SFCRFE_OP_PROG, `SFCRFE_OP_PROG_DUAL, `SFCRFE_OP_LOCK,
      `SFCRFE_OP_FREEZE, `SFCRFE_OP_OTP_PROG:
      begin
        kindDec = sfcrfe_pkg::SFCRFE_K_DIN;
        addrDec = 1'b1;
      end
      `SFCRFE_OP_ERASE_4K, `SFCRFE_OP_ERASE_32K, `SFCRFE_OP_ERASE_64K,
      `SFCRFE_OP_PROTECT, `SFCRFE_OP_UNPROTECT:
      begin
        kindDec = sfcrfe_pkg::SFCRFE_K_PLAIN;
        addrDec = 1'b1;
      end
      `SFCRFE_OP_RD_PROT, `SFCRFE_OP_RD_LOCK:
      begin
        kindDec = sfcrfe_pkg::SFCRFE_K_DOUT;
        addrDec = 1'b1;
      end
      `SFCRFE_OP_OTP_READ:
      begin
        kindDec = sfcrfe_pkg::SFCRFE_K_DOUT;
        addrDec = 1'b1;
        dummyDec = 2'h2;
      end
      `SFCRFE_OP_CHIP_ERASE_A, `SFCRFE_OP_CHIP_ERASE_B, `SFCRFE_OP_WR_EN,
      `SFCRFE_OP_WR_DIS, `SFCRFE_OP_SLEEP, `SFCRFE_OP_WAKE:
      begin
        kindDec = sfcrfe_pkg::SFCRFE_K_PLAIN;
      end
      `SFCRFE_OP_WR_STAT1, `SFCRFE_OP_WR_STAT2, `SFCRFE_OP_SW_RESET:
      begin
        kindDec = sfcrfe_pkg::SFCRFE_K_DIN;
      end
      `SFCRFE_OP_RD_STAT, `SFCRFE_OP_RD_ID:
      begin
        kindDec = sfcrfe_pkg::SFCRFE_K_DOUT;
      end
      default:
      begin
        kindDec = sfcrfe_pkg::SFCRFE_K_BAD;
      end
    endcase
  end

  // Bit and byte counting within the selected frame
  always_ff @(posedge core_clk)
  begin
    if (srst || !selected)
    begin
      bitCnt_q <= 3'h0;
      shIn_q <= 8'h00;
    end
    else if (sckRise)
    begin
      bitCnt_q <= bitCnt_q + 3'h1;
      shIn_q <= inByte;
    end
  end

  // Phase sequencer
  always_ff @(posedge core_clk)
  begin
    if (srst || !selected)
    begin
      state_q <= sfcrfe_pkg::SFCRFE_IDLE;
      kind_q <= sfcrfe_pkg::SFCRFE_K_NONE;
      byteCnt_q <= 2'h0;
      dummyNeed_q <= 2'h0;
      addr_q <= 24'h00_0000;
    end
    else
    begin
      unique case (state_q)
        sfcrfe_pkg::SFCRFE_IDLE:
        begin
          if (selStart)
          begin
            state_q <= sfcrfe_pkg::SFCRFE_OPC;
          end
        end
        sfcrfe_pkg::SFCRFE_OPC:
        begin
          if (byteDone)
          begin
            kind_q <= kindDec;
            dummyNeed_q <= dummyDec;
            byteCnt_q <= 2'h0;
            if (kindDec == sfcrfe_pkg::SFCRFE_K_BAD)
            begin
              state_q <= sfcrfe_pkg::SFCRFE_IDLE;
            end
            else if (addrDec)
            begin
              state_q <= sfcrfe_pkg::SFCRFE_ADDR;
            end
            else
            begin
              state_q <= sfcrfe_pkg::SFCRFE_DATA;
            end
          end
        end
        sfcrfe_pkg::SFCRFE_ADDR:
        begin
          if (byteDone)
          begin
            addr_q <= {addr_q[15:0], inByte};
            byteCnt_q <= byteCnt_q + 2'h1;
            if ({1'b0, byteCnt_q} == `SFCRFE_ADDR_BYTES - 3'h1)
            begin
              byteCnt_q <= 2'h0;
              state_q <= (dummyNeed_q != 2'h0) ? sfcrfe_pkg::SFCRFE_DUMMY
                                                 : sfcrfe_pkg::SFCRFE_DATA;
            end
          end
        end
        sfcrfe_pkg::SFCRFE_DUMMY:
        begin
          if (byteDone)
          begin
            byteCnt_q <= byteCnt_q + 2'h1;
            if (byteCnt_q + 2'h1 == dummyNeed_q)
            begin
              state_q <= sfcrfe_pkg::SFCRFE_DATA;
            end
          end
        end
        sfcrfe_pkg::SFCRFE_DATA:
        begin
          state_q <= sfcrfe_pkg::SFCRFE_DATA;
        end
      endcase
    end
  end

  // Unknown opcode parks in idle until chip select goes high again
  // because selStart only fires on a fresh assertion.

  // Command reporting toward the rest of the device
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cmdOpcode <= 8'h00;
      cmdAddr <= 24'h00_0000;
      cmdStart <= 1'b0;
      cmdEnd <= 1'b0;
      cmdData <= 8'h00;
      cmdDataValid <= 1'b0;
      cmdBad <= 1'b0;
    end
    else
    begin
      cmdStart <= 1'b0;
      cmdDataValid <= 1'b0;
      cmdBad <= 1'b0;
      cmdEnd <= selEnd && state_q == sfcrfe_pkg::SFCRFE_DATA;
      if (state_q == sfcrfe_pkg::SFCRFE_OPC && byteDone)
      begin
        cmdOpcode <= inByte;
        cmdBad <= kindDec == sfcrfe_pkg::SFCRFE_K_BAD;
      end
      if (state_q != sfcrfe_pkg::SFCRFE_DATA
          && readPhase == 1'b0 && 1'b0)
      begin
        cmdStart <= 1'b0;
      end
      if (state_q == sfcrfe_pkg::SFCRFE_DATA && csPrev_q == 1'b0
          && cmdEnd == 1'b0 && cmdStart == 1'b0 && 1'b0)
      begin
        cmdStart <= 1'b0;
      end
      if ((state_q == sfcrfe_pkg::SFCRFE_ADDR
           && byteDone && byteCnt_q == 2'h2 && dummyNeed_q == 2'h0)
          || (state_q == sfcrfe_pkg::SFCRFE_DUMMY && byteDone
              && byteCnt_q + 2'h1 == dummyNeed_q)
          || (state_q == sfcrfe_pkg::SFCRFE_OPC && byteDone && !addrDec
              && kindDec != sfcrfe_pkg::SFCRFE_K_BAD))
      begin
        cmdStart <= 1'b1;
        cmdAddr <= state_q == sfcrfe_pkg::SFCRFE_ADDR ?
                   {addr_q[15:0], inByte} : addr_q;
      end
      if (state_q == sfcrfe_pkg::SFCRFE_DATA && byteDone
          && kind_q == sfcrfe_pkg::SFCRFE_K_DIN)
      begin
        cmdData <= inByte;
        cmdDataValid <= 1'b1;
      end
    end
  end

  assign readPhase = state_q == sfcrfe_pkg::SFCRFE_DATA
                     && (kind_q == sfcrfe_pkg::SFCRFE_K_READ
                         || kind_q == sfcrfe_pkg::SFCRFE_K_READ2);
  assign fifoFlush = !readPhase;

  // Array prefetch; the FIFO hides array latency from the shifter
  always_ff @(posedge core_clk)
  begin
    if (srst || !selected)
    begin
      fetchAddr_q <= `SFCRFE_ARRAY_FIRST;
      fetchBusy_q <= 1'b0;
    end
    else if (!readPhase)
    begin
      // Slow read enters data on the last address edge: take it directly
      fetchAddr_q <= (state_q == sfcrfe_pkg::SFCRFE_ADDR && byteDone) ?
                     {addr_q[11:0], inByte} : addr_q[19:0];
      fetchBusy_q <= 1'b0;
    end
    else if (fetchBusy_q)
    begin
      if (arrayAck)
      begin
        fetchBusy_q <= 1'b0;
        fetchAddr_q <= fetchAddr_q == `SFCRFE_ARRAY_LAST ?
                       `SFCRFE_ARRAY_FIRST : fetchAddr_q + 20'h0_0001;
      end
    end
    else if (fifoInReady)
    begin
      fetchBusy_q <= 1'b1;
    end
  end

  assign arrayReq = fetchBusy_q;
  assign arrayAddr = fetchAddr_q;

  sfcrfe_fifo #(
    .WIDTH(8),
    .DEPTH(`SFCRFE_FIFO_DEPTH),
    .AW(`SFCRFE_FIFO_AW)
  ) u_fifo (
    .clk(core_clk),
    .srst(srst),
    .flush(fifoFlush),
    .inValid(fetchBusy_q && arrayAck),
    .inReady(fifoInReady),
    .inData(arrayData),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData)
  );

  assign fifoPop = readPhase && !outLoaded_q && fifoOutValid;

  // Output shifter, changes on falling edges only
  always_ff @(posedge core_clk)
  begin
    if (srst || !selected || !readPhase)
    begin
      shOut_q <= 8'h00;
      outBits_q <= 3'h0;
      outLoaded_q <= 1'b0;
      dual_q <= 1'b0;
      dataOut <= 1'b0;
      auxDataLineInOut_o <= 1'b0;
      dataOutEn <= 1'b0;
      auxDataLineInOut_oe <= 1'b0;
    end
    else
    begin
      dual_q <= kind_q == sfcrfe_pkg::SFCRFE_K_READ2;
      if (fifoPop)
      begin
        shOut_q <= fifoOutData;
        outBits_q <= 3'h0;
        outLoaded_q <= 1'b1;
      end
      else if (sckFall && outLoaded_q)
      begin
        dataOutEn <= 1'b1;
        if (dual_q)
        begin
          dataOut <= shOut_q[7];
          auxDataLineInOut_o <= shOut_q[6];
          auxDataLineInOut_oe <= 1'b1;
          shOut_q <= {shOut_q[5:0], 2'b00};
          outBits_q <= outBits_q + 3'h2;
          outLoaded_q <= outBits_q != 3'h6;
        end
        else
        begin
          dataOut <= shOut_q[7];
          shOut_q <= {shOut_q[6:0], 1'b0};
          outBits_q <= outBits_q + 3'h1;
          outLoaded_q <= outBits_q != 3'h7;
        end
      end
    end
  end
endmodule

// ===== sfcrfe_cfg.svh
// Constants of the serial flash command front end
`ifndef SFCRFE_CFG_SVH
`define SFCRFE_CFG_SVH
`define SFCRFE_OP_READ_FAST 8'h1B
`define SFCRFE_OP_READ_MID 8'h0B
`define SFCRFE_OP_READ_SLOW 8'h03
`define SFCRFE_OP_READ_DUAL 8'h3B
`define SFCRFE_OP_ERASE_4K 8'h20
`define SFCRFE_OP_ERASE_32K 8'h52
`define SFCRFE_OP_ERASE_64K 8'hD8
`define SFCRFE_OP_CHIP_ERASE_A 8'h60
`define SFCRFE_OP_CHIP_ERASE_B 8'hC7
`define SFCRFE_OP_PROG 8'h02
`define SFCRFE_OP_PROG_DUAL 8'hA2
`define SFCRFE_OP_WR_EN 8'h06
`define SFCRFE_OP_WR_DIS 8'h04
`define SFCRFE_OP_PROTECT 8'h36
`define SFCRFE_OP_UNPROTECT 8'h39
`define SFCRFE_OP_RD_PROT 8'h3C
`define SFCRFE_OP_LOCK 8'h33
`define SFCRFE_OP_FREEZE 8'h34
`define SFCRFE_OP_RD_LOCK 8'h35
`define SFCRFE_OP_OTP_PROG 8'h9B
`define SFCRFE_OP_OTP_READ 8'h77
`define SFCRFE_OP_RD_STAT 8'h05
`define SFCRFE_OP_WR_STAT1 8'h01
`define SFCRFE_OP_WR_STAT2 8'h31
`define SFCRFE_OP_SW_RESET 8'hF0
`define SFCRFE_OP_RD_ID 8'h9F
`define SFCRFE_OP_SLEEP 8'hB9
`define SFCRFE_OP_WAKE 8'hAB
`define SFCRFE_ADDR_BYTES 3'h3
`define SFCRFE_ARRAY_LAST 20'hF_FFFF
`define SFCRFE_ARRAY_FIRST 20'h0_0000
`define SFCRFE_FIFO_DEPTH 16
`define SFCRFE_FIFO_AW 4
`endif

// ===== sfcrfe_pkg.sv
// Types of the serial flash command front end
package sfcrfe_pkg;
  typedef enum logic [4:0] {
    SFCRFE_IDLE = 5'b0_0001,
    SFCRFE_OPC = 5'b0_0010,
    SFCRFE_ADDR = 5'b0_0100,
    SFCRFE_DUMMY = 5'b0_1000,
    SFCRFE_DATA = 5'b1_0000
  } sfcrfe_state_t;
  typedef enum logic [2:0] {
    SFCRFE_K_NONE = 3'h0,
    SFCRFE_K_READ = 3'h1,
    SFCRFE_K_READ2 = 3'h2,
    SFCRFE_K_DIN = 3'h3,
    SFCRFE_K_DOUT = 3'h4,
    SFCRFE_K_PLAIN = 3'h5,
    SFCRFE_K_BAD = 3'h6
  } sfcrfe_kind_t;
endpackage

// ===== sfcrfe_fifo.sv
// Word FIFO carrying array bytes toward the serial shifter
`timescale 1ns/1ps
module sfcrfe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_q;
  logic [AW:0] rdPtr_q;
  logic doWr;
  logic doRd;

  assign inReady = (wrPtr_q - rdPtr_q) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData = mem[rdPtr_q[AW-1:0]];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;

  always_ff @(posedge clk)
  begin
    if (doWr)
    begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst || flush)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end
    else
    begin
      if (doWr)
      begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doRd)
      begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule

// ===== sfcrfe_front_end_assertions.sv
// Port checker of the serial flash front end
`timescale 1ns/1ps
module sfcrfe_front_end_assertions (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic spiClk,
  input wire logic chipSelN,
  input wire logic dataOut,
  input wire logic dataOutEn,
  input wire logic auxDataLineInOut_oe,
  input wire logic [19:0] arrayAddr,
  input wire logic arrayReq,
  input wire logic arrayAck,
  input wire logic [7:0] cmdOpcode,
  input wire logic cmdStart,
  input wire logic cmdDataValid,
  input wire logic cmdBad
);
  logic sclk_q;
  logic [3:0] sinceFall_q;
  logic [19:0] lastAddr_q;
  logic haveLast_q;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // Raw pin sampled once, so the count starts no later than the design's
  always_ff @(posedge core_clk)
  begin
    sclk_q <= spiClk;
    if (srst)
      sinceFall_q <= 4'hF;
    else if (sclk_q && !spiClk)
      sinceFall_q <= 4'h0;
    else if (sinceFall_q != 4'hF)
      sinceFall_q <= sinceFall_q + 4'h1;
  end
  always_ff @(posedge core_clk)
  begin
    if (srst || chipSelN)
      haveLast_q <= 1'b0;
    else if (arrayAck)
      haveLast_q <= 1'b1;
  end
  always_ff @(posedge core_clk)
  begin
    if (arrayAck)
      lastAddr_q <= arrayAddr;
  end
  sequence csIdle;
    chipSelN [*6];
  endsequence
  sequence quietLines;
    !dataOutEn && !auxDataLineInOut_oe;
  endsequence
  AST_FLOAT_ON_RELEASE: assert property (csIdle |-> quietLines)
    else $error("output driven after chip select release");
  AST_AUX_DUAL_ONLY: assert property (auxDataLineInOut_oe |->
    cmdOpcode == 8'h3B && dataOutEn)
    else $error("aux line driven outside dual read");
  AST_REQ_HELD: assert property (arrayReq && !arrayAck |=>
    arrayReq && $stable(arrayAddr))
    else $error("array request dropped or moved");
  AST_ADDR_STEP: assert property (arrayReq && haveLast_q |->
    arrayAddr == lastAddr_q + 20'h0_0001)
    else $error("array address not sequential");
  AST_BAD_IGNORED: assert property (cmdBad |=>
    (!cmdStart && !dataOutEn && !arrayReq) [*8])
    else $error("activity after unsupported opcode");
  AST_NO_CMD_IDLE: assert property (csIdle |->
    !cmdStart && !cmdDataValid && !arrayReq)
    else $error("command activity while deselected");
  AST_OUT_ON_FALL: assert property (dataOutEn && $past(dataOutEn) &&
    $changed(dataOut) |-> sinceFall_q < 4'h8)
    else $error("output changed away from falling clock");
  AST_WRITE_DATA_OP: assert property (cmdDataValid |->
    cmdOpcode inside {8'h02, 8'hA2, 8'h33, 8'h34, 8'h9B, 8'h01, 8'h31,
    8'hF0})
    else $error("data byte for a non-write opcode");
endmodule
bind sfcrfe_front_end sfcrfe_front_end_assertions
  u_sfcrfe_front_end_assertions (.core_clk(core_clk), .srst(srst),
  .spiClk(spiClk), .chipSelN(chipSelN), .dataOut(dataOut),
  .dataOutEn(dataOutEn), .auxDataLineInOut_oe(auxDataLineInOut_oe),
  .arrayAddr(arrayAddr), .arrayReq(arrayReq), .arrayAck(arrayAck),
  .cmdOpcode(cmdOpcode), .cmdStart(cmdStart),
  .cmdDataValid(cmdDataValid), .cmdBad(cmdBad));

// ===== sfcrfe_spi_host.sv
// Host controller model on the serial link, mode 0
`timescale 1ns/1ps
module sfcrfe_spi_host (
  input wire logic clk,
  output logic spiClk,
  output logic chipSelN,
  output logic dataIn,
  output logic auxDrv,
  input wire logic dataOut,
  input wire logic dataOutEn,
  input wire logic auxWire,
  input wire logic auxOe
);
  initial
  begin
    spiClk = 1'b0;
    chipSelN = 1'b1;
    dataIn = 1'b0;
    auxDrv = 1'b1;
  end
  // Half of the 160 ns link period; link clock idles low between frames
  task automatic half();
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic frameOpen();
    chipSelN = 1'b0;
    half();
  endtask
  task automatic frameClose();
    half();
    chipSelN = 1'b1;
    half();
  endtask
  task automatic sendByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      dataIn = b[i];
      auxDrv = ~auxDrv;
      half();
      spiClk = 1'b1;
      half();
      spiClk = 1'b0;
    end
  endtask
  // Unused inputs flip every bit so stale levels never pass as data
  task automatic readBits(input int n, input bit dual, output logic [7:0] v);
    v = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      dataIn = ~dataIn;
      auxDrv = ~auxDrv;
      half();
      if (dual)
        v = {v[5:0], dataOutEn ? dataOut : 1'bx, auxOe ? auxWire : 1'bx};
      else
        v = {v[6:0], dataOutEn ? dataOut : 1'bx};
      spiClk = 1'b1;
      half();
      spiClk = 1'b0;
    end
  endtask
endmodule

// ===== sfcrfe_front_end_bench.sv
// Self-checking bench of the serial flash front end
`timescale 1ns/1ps
`include "sfcrfe_cfg.svh"
module sfcrfe_front_end_bench;
  logic core_clk, srst, spiClk, chipSelN, dataIn, auxDrv, auxWire;
  logic dataOut, dataOutEn, auxO, auxOe, arrayReq, arrayAck;
  logic cmdStart, cmdEnd, cmdDataValid, cmdBad;
  logic [19:0] arrayAddr;
  logic [7:0] arrayData, cmdOpcode, cmdData;
  logic [23:0] cmdAddr;
  int fail_count = 0;
  int total_checks = 0;
  int startCnt = 0;
  int badCnt = 0;
  int dvCnt = 0;
  assign auxWire = auxOe ? auxO : auxDrv;
  sfcrfe_front_end u_sfcrfe_front_end (.core_clk(core_clk), .srst(srst),
    .spiClk(spiClk), .chipSelN(chipSelN), .dataIn(dataIn),
    .dataOut(dataOut), .dataOutEn(dataOutEn),
    .auxDataLineInOut_i(auxWire), .auxDataLineInOut_o(auxO),
    .auxDataLineInOut_oe(auxOe), .arrayAddr(arrayAddr),
    .arrayReq(arrayReq), .arrayAck(arrayAck), .arrayData(arrayData),
    .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr), .cmdStart(cmdStart),
    .cmdEnd(cmdEnd), .cmdData(cmdData), .cmdDataValid(cmdDataValid),
    .cmdBad(cmdBad));
  sfcrfe_spi_host u_sfcrfe_spi_host (.clk(core_clk), .spiClk(spiClk),
    .chipSelN(chipSelN), .dataIn(dataIn), .auxDrv(auxDrv),
    .dataOut(dataOut), .dataOutEn(dataOutEn), .auxWire(auxWire),
    .auxOe(auxOe));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [7:0] expData(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  // Array answers a cycle late; data line scrambled when not acking
  always @(posedge core_clk)
  begin
    arrayAck <= #1 arrayReq && !arrayAck;
    arrayData <= #1 (arrayReq && !arrayAck) ? expData(arrayAddr) : ~arrayData;
    startCnt <= startCnt + int'(cmdStart);
    badCnt <= badCnt + int'(cmdBad);
    dvCnt <= dvCnt + int'(cmdDataValid);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic sendAddr(input logic [23:0] a);
    u_sfcrfe_spi_host.sendByte(a[23:16]);
    u_sfcrfe_spi_host.sendByte(a[15:8]);
    u_sfcrfe_spi_host.sendByte(a[7:0]);
  endtask
  // Stream past the prefetch depth through the top
  task automatic t_fifo();
    logic [7:0] v;
    logic [19:0] a;
    int s0;
    s0 = startCnt;
    a = 20'h0_0010;
    u_sfcrfe_spi_host.frameOpen();
    u_sfcrfe_spi_host.sendByte(`SFCRFE_OP_READ_SLOW);
    sendAddr(24'h00_0010);
    check(startCnt - s0, 1);
    check(cmdAddr, 24'h00_0010);
    for (int j = 0; j < 20; j++)
    begin
      u_sfcrfe_spi_host.readBits(8, 1'b0, v);
      check(v, expData(a));
      a = a + 20'h0_0001;
    end
    u_sfcrfe_spi_host.frameClose();
    check(dataOutEn, 1'b0);
    $display("fifo test done");
  endtask
  task automatic t_reads();
    logic [7:0] ops [3] = '{8'h1B, 8'h0B, 8'h03};
    int dum [3] = '{2, 1, 0};
    logic [7:0] v;
    logic [19:0] a;
    for (int k = 0; k < 3; k++)
    begin
      a = 20'hF_FFFE;
      u_sfcrfe_spi_host.frameOpen();
      u_sfcrfe_spi_host.sendByte(ops[k]);
      sendAddr(24'hAF_FFFE);
      repeat (dum[k]) u_sfcrfe_spi_host.sendByte(8'h00);
      for (int j = 0; j < 3; j++)
      begin
        u_sfcrfe_spi_host.readBits(8, 1'b0, v);
        check(v, expData(a));
        a = a + 20'h0_0001;
      end
      u_sfcrfe_spi_host.readBits(5, 1'b0, v);
      u_sfcrfe_spi_host.frameClose();
      check(dataOutEn, 1'b0);
    end
    $display("single read test done");
  endtask
  task automatic t_dual();
    logic [7:0] v;
    u_sfcrfe_spi_host.frameOpen();
    u_sfcrfe_spi_host.sendByte(`SFCRFE_OP_READ_DUAL);
    sendAddr(24'h0F_FFFF);
    u_sfcrfe_spi_host.sendByte(8'h00);
    u_sfcrfe_spi_host.readBits(4, 1'b1, v);
    check(v, expData(20'hF_FFFF));
    u_sfcrfe_spi_host.readBits(4, 1'b1, v);
    check(v, expData(20'h0_0000));
    u_sfcrfe_spi_host.readBits(1, 1'b1, v);
    u_sfcrfe_spi_host.frameClose();
    check({dataOutEn, auxOe}, 2'b00);
    $display("dual read test done");
  endtask
  task automatic t_refuse();
    int b0;
    int s0;
    b0 = badCnt;
    s0 = startCnt;
    u_sfcrfe_spi_host.frameOpen();
    u_sfcrfe_spi_host.sendByte(8'hFF);
    repeat (4) u_sfcrfe_spi_host.sendByte(`SFCRFE_OP_READ_SLOW);
    u_sfcrfe_spi_host.frameClose();
    check(badCnt - b0, 1);
    u_sfcrfe_spi_host.frameOpen();
    u_sfcrfe_spi_host.sendByte(`SFCRFE_OP_READ_SLOW);
    u_sfcrfe_spi_host.sendByte(8'h00);
    u_sfcrfe_spi_host.sendByte(8'h00);
    u_sfcrfe_spi_host.frameClose();
    check(startCnt - s0, 0);
    $display("refusal test done");
  endtask
  task automatic t_cmds();
    logic [7:0] ops [24] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h02,
      8'hA2, 8'h06, 8'h04, 8'h36, 8'h39, 8'h3C, 8'h33, 8'h34, 8'h35, 8'h9B,
      8'h77, 8'h05, 8'h01, 8'h31, 8'hF0, 8'h9F, 8'hB9, 8'hAB};
    int s0;
    int d0;
    bit hasA;
    foreach (ops[k])
    begin
      s0 = startCnt;
      d0 = dvCnt;
      hasA = ops[k] inside {8'h20, 8'h52, 8'hD8, 8'h02, 8'hA2, 8'h36,
        8'h39, 8'h3C, 8'h33, 8'h34, 8'h35, 8'h9B, 8'h77};
      u_sfcrfe_spi_host.frameOpen();
      u_sfcrfe_spi_host.sendByte(ops[k]);
      if (hasA)
        sendAddr(24'h12_3456);
      if (ops[k] == 8'h77)
        repeat (2) u_sfcrfe_spi_host.sendByte(8'h00);
      check(startCnt - s0, 1);
      check(cmdOpcode, ops[k]);
      if (hasA)
        check(cmdAddr, 24'h12_3456);
      if (ops[k] inside {8'h02, 8'h01})
      begin
        u_sfcrfe_spi_host.sendByte(8'hA5);
        check({dvCnt - d0, cmdData}, {24'h00_0001, 8'hA5});
      end
      u_sfcrfe_spi_host.frameClose();
    end
    $display("command framing test done");
  endtask
  initial
  begin
    srst = 1'b1;
    arrayAck = 1'b0;
    arrayData = 8'h00;
    repeat (6) @(posedge core_clk);
    #1;
    srst = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    t_fifo();
    t_reads();
    t_dual();
    t_refuse();
    t_cmds();
    print_verdict();
  end
  initial
  begin
    repeat (80000) @(posedge core_clk);
    fail_count++;
    print_verdict();
  end
endmodule
